// ==== graphics_aperture_map.svh ====
// Offsets, field positions and reset values of the aperture size register.
// Assumes inclusion by bare name from the package and design files.
`ifndef GRAPHICS_APERTURE_MAP_SVH
`define GRAPHICS_APERTURE_MAP_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define APSZ_OFFSET      8'hb4
`define APSZ_RESET       8'h00
`define APSZ_MASK_MSB    5
`define APSZ_MASK_LSB    0
`define APSZ_RSVD_MSB    7
`define APSZ_RSVD_LSB    6
`define APSZ_MASK_W      6

// ==========================================================================
// Aperture base bits steered by the mask
// ==========================================================================
`define BASE_GATE_MSB    27
`define BASE_GATE_LSB    22
`define BASE_GATE_RESET  6'h00

`endif

// ==== graphics_aperture_pkg.sv ====
// Types shared by the aperture size register and its base-bit gate.
// Assumes graphics_aperture_map.svh is on the include path.
`include "graphics_aperture_map.svh"

package graphics_aperture_pkg;

   // =======================================================================
   // Configuration access carrier
   // =======================================================================
   typedef struct packed {
      logic       wr;      // Write strobe, one cycle
      logic       rd;      // Read strobe, one cycle
      logic [7:0] addr;    // Configuration byte offset
      logic [7:0] wdata;   // Write byte
   } cfg_req_type;

   // Six gated aperture base bits, bit 0 is base bit 22
   typedef logic [`APSZ_MASK_W-1:0] mask_type;

   // =======================================================================
   // Decoded aperture sizes
   // =======================================================================
   typedef enum logic [2:0] {
      SIZE_256MB,
      SIZE_128MB,
      SIZE_64MB,
      SIZE_32MB,
      SIZE_16MB,
      SIZE_8MB,
      SIZE_4MB,
      SIZE_ILLEGAL
   } size_type;

endpackage

// ==== aperture_base_gate.sv ====
// Storage for aperture base bits 27:22, gated bit by bit by the size mask.
// Assumes the mask and write strobe come from logic on the same clock.
module aperture_base_gate
   import graphics_aperture_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     rst,
   input  wire mask_type mask,
   input  wire logic     base_wr,
   input  wire mask_type base_wdata,
   output mask_type      base_bits
);

   // =======================================================================
   // Gated storage
   // =======================================================================
   mask_type base_reg;    // Held base bits 27:22
   mask_type base_next;   // Candidate after write and masking
   mask_type raw_value;   // Write data or hold value

   assign raw_value = base_wr ? base_wdata : base_reg;
   assign base_next = raw_value & mask;

   // A cleared mask bit also wipes the stored bit, so it stays zero later
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         base_reg <= `BASE_GATE_RESET;
      end else begin
         base_reg <= base_next;
      end
   end

   assign base_bits = base_reg;

endmodule

// ==== graphics_aperture_size_mask.sv ====
// Aperture size register: a six-bit mask over aperture base bits 27:22,
// with a byte-wide configuration access port and decoded size output.
// Assumes configuration strobes are synchronous to ref_clk.
`include "graphics_aperture_map.svh"

module graphics_aperture_size_mask
   import graphics_aperture_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire cfg_req_type cfg_req,
   output logic [7:0]       cfg_rdata,
   output logic             cfg_ack,
   input  wire logic        base_wr,
   input  wire mask_type    base_wdata,
   output mask_type         base_bits,
   output mask_type         aperture_size_mask,
   output size_type         aperture_size
);

   // =======================================================================
   // Decode helpers
   // =======================================================================
   // Maps a mask onto its aperture size; gaps in the fill are illegal
   function automatic size_type size_of(input mask_type m);
      size_type s;
      s = SIZE_ILLEGAL;
      case (m)
         6'h00:   s = SIZE_256MB;
         6'h20:   s = SIZE_128MB;
         6'h30:   s = SIZE_64MB;
         6'h38:   s = SIZE_32MB;
         6'h3c:   s = SIZE_16MB;
         6'h3e:   s = SIZE_8MB;
         6'h3f:   s = SIZE_4MB;
         default: s = SIZE_ILLEGAL;
      endcase
      return s;
   endfunction

   // =======================================================================
   // Address decode and next values
   // =======================================================================
   logic       hit_size;     // Access targets the size register
   logic       any_access;   // Read or write strobe present
   mask_type   mask_reg;     // Stored mask bits
   mask_type   mask_next;    // Mask after this cycle's write
   size_type   size_reg;     // Registered decoded size
   logic [7:0] rdata_next;   // Read data for this cycle
   logic [7:0] rdata_reg;    // Registered read data
   logic       ack_reg;      // Registered acknowledge

   assign hit_size   = (cfg_req.addr == `APSZ_OFFSET);
   assign any_access = cfg_req.wr | cfg_req.rd;
   assign mask_next  = (cfg_req.wr && hit_size) ?
                       cfg_req.wdata[`APSZ_MASK_MSB:`APSZ_MASK_LSB] : mask_reg;
   assign rdata_next = (cfg_req.rd && hit_size) ? {2'b00, mask_reg} : 8'h00;

   // =======================================================================
   // Register storage
   // =======================================================================
   // Mask clears at reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mask_reg <= mask_type'(`APSZ_RESET);
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Read answer one cycle after the strobe; unmapped offsets give zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         ack_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         ack_reg   <= any_access;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         size_reg <= SIZE_256MB;
      end else begin
         size_reg <= size_of(mask_next);
      end
   end

   // =======================================================================
   // Base bit gating
   // =======================================================================
   // One-to-one bit mapping
   aperture_base_gate u_gate (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .mask       (mask_reg),
      .base_wr    (base_wr),
      .base_wdata (base_wdata),
      .base_bits  (base_bits)
   );

   assign cfg_rdata          = rdata_reg;
   assign cfg_ack            = ack_reg;
   assign aperture_size_mask = mask_reg;
   assign aperture_size      = size_reg;

   // =======================================================================
   // Assertions
   // =======================================================================
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_mask_write;
      (cfg_req.wr && hit_size) |=> (mask_reg == $past(cfg_req.wdata[5:0]));
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask did not take written low bits");

   property p_zero_forced;
      ##1 ((base_bits & ~$past(mask_reg)) == 6'h00);
   endproperty
   a_zero_forced: assert property (p_zero_forced)
      else $error("base bit nonzero under cleared mask");

   property p_base_store;
      base_wr |=> (base_bits == ($past(base_wdata) & $past(mask_reg)));
   endproperty
   a_base_store: assert property (p_base_store)
      else $error("enabled base bit did not store write");

   property p_reset_value;
      $fell(rst) |-> (mask_reg == 6'h00 && aperture_size == SIZE_256MB);
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("mask or size wrong after reset");

   property p_size_decode;
      (mask_reg == 6'h38) |-> (aperture_size == SIZE_32MB);
   endproperty
   a_size_decode: assert property (p_size_decode)
      else $error("mask 111000 not decoded as 32 MB");

   property p_size_max;
      (mask_reg == 6'h3f) |-> (aperture_size == SIZE_4MB);
   endproperty
   a_size_max: assert property (p_size_max)
      else $error("mask 111111 not decoded as 4 MB");

   property p_rsvd_read;
      (cfg_req.rd && hit_size) |=> (cfg_ack && cfg_rdata[7:6] == 2'b00
                                    && cfg_rdata[5:0] == $past(mask_reg));
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("size read wrong or reserved bits nonzero");

   // Mask changes only on a write that hits the size register
   property p_mask_hold;
      !(cfg_req.wr && hit_size) |=> $stable(mask_reg);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("mask changed without a size register write");

   // Read data falls back to zero when no size read was taken
   property p_rdata_idle;
      !(cfg_req.rd && hit_size) |=> (cfg_rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data nonzero without a size read");

   // Every strobe, mapped or not, is acknowledged one cycle later
   property p_ack_follows;
      any_access |=> cfg_ack;
   endproperty
   a_ack_follows: assert property (p_ack_follows)
      else $error("access not acknowledged");

   // Remaining thermometer codes of the size decode
   property p_size_256;
      (mask_reg == 6'h00) |-> (aperture_size == SIZE_256MB);
   endproperty
   a_size_256: assert property (p_size_256)
      else $error("mask 000000 not decoded as 256 MB");

   property p_size_128;
      (mask_reg == 6'h20) |-> (aperture_size == SIZE_128MB);
   endproperty
   a_size_128: assert property (p_size_128)
      else $error("mask 100000 not decoded as 128 MB");

   property p_size_64;
      (mask_reg == 6'h30) |-> (aperture_size == SIZE_64MB);
   endproperty
   a_size_64: assert property (p_size_64)
      else $error("mask 110000 not decoded as 64 MB");

   property p_size_16;
      (mask_reg == 6'h3c) |-> (aperture_size == SIZE_16MB);
   endproperty
   a_size_16: assert property (p_size_16)
      else $error("mask 111100 not decoded as 16 MB");

   property p_size_8;
      (mask_reg == 6'h3e) |-> (aperture_size == SIZE_8MB);
   endproperty
   a_size_8: assert property (p_size_8)
      else $error("mask 111110 not decoded as 8 MB");

   // A gap in the fill is not a legal size and must say so
   property p_size_gap;
      (mask_reg == 6'h15) |-> (aperture_size == SIZE_ILLEGAL);
   endproperty
   a_size_gap: assert property (p_size_gap)
      else $error("gapped mask not flagged illegal");

   // Scenario covers
   c_small_aperture: cover property (mask_reg == 6'h3f ##1 base_wr);
   c_illegal_mask:   cover property (aperture_size == SIZE_ILLEGAL);
   c_mid_aperture:   cover property (mask_reg == 6'h30 ##1 base_bits != 6'h00);
   c_read_back:      cover property (cfg_req.rd && hit_size && mask_reg != 6'h00);

endmodule

// ==== tb_graphics_aperture_size_mask.sv ====
// Self-checking bench for the aperture size register and its base-bit gate.
// Assumes the design package, map header and design files compile first.
`include "graphics_aperture_map.svh"
module tb_graphics_aperture_size_mask
   import graphics_aperture_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ======================================================================
   // Signals
   // ======================================================================
   logic        ref_clk;            // 10 MHz bench clock
   logic        rst;                // Async reset, active high
   cfg_req_type cfg_req;            // Configuration strobes
   logic [7:0]  cfg_rdata;          // Read data seen
   logic        cfg_ack;            // Access acknowledge
   logic        base_wr;            // Base bit write strobe
   mask_type    base_wdata;         // Base bit write value
   mask_type    base_bits;          // Gated base bits 27:22
   mask_type    aperture_size_mask; // Current mask
   size_type    aperture_size;      // Decoded size
   logic [7:0]  rd;                 // Last read byte
   mask_type    code;               // Thermometer code under test
   int          fails = 0;
   int          n_compared = 0;
   int          cycles = 0;

   graphics_aperture_size_mask graphics_aperture_size_mask_i (
      .ref_clk            (ref_clk),
      .rst                (rst),
      .cfg_req            (cfg_req),
      .cfg_rdata          (cfg_rdata),
      .cfg_ack            (cfg_ack),
      .base_wr            (base_wr),
      .base_wdata         (base_wdata),
      .base_bits          (base_bits),
      .aperture_size_mask (aperture_size_mask),
      .aperture_size      (aperture_size)
   );

   // ======================================================================
   // Clock and hang guard
   // ======================================================================
   always #50 ref_clk = ~ref_clk;

   // Whole run is about a hundred cycles, so 2000 means a hang
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         wrap_up();
      end
   end

   // ======================================================================
   // Tasks
   // ======================================================================
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One strobe cycle; answer lands exactly one edge later
   task automatic cfg_access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      cfg_req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
      @(posedge ref_clk);
      cfg_req <= '0;
      #1;
      check("cfg_ack", {7'h00, cfg_ack}, 8'h01);
      rd = cfg_rdata;
   endtask

   task automatic base_write(input mask_type v);
      @(posedge ref_clk);
      base_wr    <= 1'b1;
      base_wdata <= v;
      @(posedge ref_clk);
      base_wr    <= 1'b0;
      #1;
   endtask

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ======================================================================
   // Main sequence
   // ======================================================================
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      cfg_req = '0;
      base_wr = 1'b0;
      base_wdata = '0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      // Defaults after reset
      check("mask", {2'b00, aperture_size_mask}, 8'h00);
      check("size", {5'h00, aperture_size}, {5'h00, SIZE_256MB});
      cfg_access(1'b0, `APSZ_OFFSET, 8'h00);
      check("rd reset", rd, 8'h00);
      base_write(6'h3f);
      check("base at mask 0", {2'b00, base_bits}, 8'h00);
      // Size programmed after a base write at mask zero
      // Every size code, with the reserved bits set in the write
      for (int i = 0; i < 7; i++) begin
         code = mask_type'(6'h3f << (6 - i));
         cfg_access(1'b1, `APSZ_OFFSET, {2'b11, code});
         check("mask", {2'b00, aperture_size_mask}, {2'b00, code});
         check("size", {5'h00, aperture_size}, {5'h00, size_type'(i)});
         cfg_access(1'b0, `APSZ_OFFSET, 8'h00);
         check("rd mask", rd, {2'b00, code});
         @(posedge ref_clk);
         #1;
         check("rd idle", cfg_rdata, 8'h00);
         base_write(6'h2a);
         check("base 2a", {2'b00, base_bits}, {2'b00, 6'h2a & code});
         base_write(6'h15);
         check("base 15", {2'b00, base_bits}, {2'b00, 6'h15 & code});
      end
      // Clearing mask bits drops the stored base bits one cycle later
      base_write(6'h2b);
      cfg_access(1'b1, `APSZ_OFFSET, 8'h38);
      @(posedge ref_clk);
      #1;
      check("base cleared", {2'b00, base_bits}, 8'h28);
      // Unmapped offset leaves the mask alone and reads zero
      cfg_access(1'b1, 8'hb5, 8'h3f);
      check("mask kept", {2'b00, aperture_size_mask}, 8'h38);
      cfg_access(1'b0, 8'hb5, 8'h00);
      check("rd unmapped", rd, 8'h00);
      // A gapped mask is flagged illegal but still gates bit by bit
      cfg_access(1'b1, `APSZ_OFFSET, 8'h15);
      check("size gap", {5'h00, aperture_size}, {5'h00, SIZE_ILLEGAL});
      base_write(6'h3f);
      check("base gap", {2'b00, base_bits}, 8'h15);
      // Second reset in mid-run restores the largest aperture
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      check("mask rst", {2'b00, aperture_size_mask}, 8'h00);
      check("base rst", {2'b00, base_bits}, 8'h00);
      wrap_up();
   end
endmodule
